// file: design/hspb_pkg.sv
// constants, types and layouts of the host serial port with bypass
`default_nettype none
package hspb_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int OVS = 8;
	// divisor is baud times 4096 per million
	localparam longint DIV_SCALE_NUM = 4096;
	localparam longint DIV_SCALE_DEN = 1_000_000;
	localparam int BAUD_MOD = int'((longint'(CLK_HZ) * DIV_SCALE_NUM) /
		(DIV_SCALE_DEN * longint'(OVS)));
	localparam int DIV_W = 16;
	localparam int ACC_W = 16;
	localparam logic [DIV_W-1:0] BAUD_DIV_RST = 16'h01d8;
	localparam logic [11:0] KEY_BAUD = 12'h0204;
	localparam logic [11:0] KEY_BRK = 12'h01a4;
	// break timeout unit is one millisecond
	localparam int BRK_UNIT_NS = 1_000_000;
	localparam int MS_CYCLES = BRK_UNIT_NS / CLK_PERIOD_NS;
	localparam int BRK_W = 18;
	localparam logic [BRK_W-1:0] BRK_MIN = 18'h0_03e8;
	localparam logic [BRK_W-1:0] BRK_MAX = 18'h3_e418;
	localparam logic [BRK_W-1:0] BRK_RST = 18'h0_0000;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BAUD = 8'h04;
	localparam logic [7:0] OFS_BRK = 8'h08;
	localparam logic [7:0] OFS_TXD = 8'h0c;
	localparam logic [7:0] OFS_RXD = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_ISTAT = 8'h18;
	localparam logic [7:0] OFS_IMASK = 8'h1c;
	localparam logic [7:0] OFS_CMD = 8'h20;
	localparam logic [31:0] CMD_BYPASS = 32'h0000_0b5a;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int NIRQ = 6;
	localparam int IRQ_RXDONE = 0;
	localparam int IRQ_TXDONE = 1;
	localparam int IRQ_PARERR = 2;
	localparam int IRQ_FRMERR = 3;
	localparam int IRQ_OVERRUN = 4;
	localparam int IRQ_BREAK = 5;
	typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} hspb_par_type;
	// control register: bits 1:0 parity, 2 two stop bits, 3 handshake, 4 send break
	typedef struct packed {
		logic send_break;
		logic flow_en;
		logic stop2;
		hspb_par_type parity;
	} hspb_cfg_type;
	localparam int CFG_W = $bits(hspb_cfg_type);
	localparam hspb_cfg_type CFG_RST = '{send_break: 1'b0, flow_en: 1'b0,
		stop2: 1'b0, parity: PAR_NONE};
	typedef struct packed {
		logic bypass;
		logic cts_n;
		logic tx_pend;
		logic tx_busy;
		logic rx_valid;
	} hspb_stat_type;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} hspb_rx_type;
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} hspb_tx_type;
endpackage
`default_nettype wire

// file: design/hspb_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module hspb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			meta_reg <= INIT;
			Q <= INIT;
		end
		else
		begin
			meta_reg <= D;
			Q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// file: design/hspb_baud.sv
// fractional oversampling tick generator driven by the stored divisor
`default_nettype none
module hspb_baud
	import hspb_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [hspb_pkg::DIV_W-1:0] DIV,
	input wire logic RUN,
	output logic TICK
);
	localparam logic [ACC_W:0] MOD = (ACC_W+1)'(BAUD_MOD);
	logic [ACC_W:0] acc_reg;
	logic [ACC_W:0] sum;
	// tick rate is divisor * OVS / 0.004096 per second, exact on average
	assign sum = acc_reg + {1'b0, DIV};
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			acc_reg <= '0;
			TICK <= 1'b0;
		end
		else if (!RUN)
		begin
			acc_reg <= '0;
			TICK <= 1'b0;
		end
		else if (sum >= MOD)
		begin
			acc_reg <= sum - MOD;
			TICK <= 1'b1;
		end
		else
		begin
			acc_reg <= sum;
			TICK <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: design/hspb_uart_port.sv
// serial host port with break reset, bypass routing and AHB-Lite registers
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`default_nettype none
module hspb_uart_port #(
	parameter int MS_CYCLES = hspb_pkg::MS_CYCLES
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	input wire logic RXD,
	output logic TXD_O,
	output logic TXD_OE,
	input wire logic CTS_N,
	output logic RTS_N_O,
	output logic RTS_N_OE,
	input wire logic [3:0] GP_I,
	output logic [3:0] GP_O,
	output logic [3:0] GP_OE,
	output logic DEEP_SLEEP,
	output logic RESET_REQ,
	output logic IRQ
);
	import hspb_pkg::*;

	localparam logic [2:0] OVS_LAST = 3'(OVS - 1);
	localparam logic [2:0] OVS_HALF = 3'(OVS / 2 - 1);
	localparam logic [3:0] GP_OE_BYP = 4'h5;
	localparam int MSC_W = $clog2(MS_CYCLES + 1);
	localparam logic [MSC_W-1:0] MS_LAST = MSC_W'(MS_CYCLES - 1);

	function automatic logic par_bit(input logic [7:0] d, input hspb_par_type p);
		par_bit = (p == PAR_ODD) ? ~^d : ^d;
	endfunction

	function automatic logic [BRK_W-1:0] brk_clamp(input logic [BRK_W-1:0] v);
		if (v < BRK_MIN)
			brk_clamp = '0;
		else if (v > BRK_MAX)
			brk_clamp = BRK_MAX;
		else
			brk_clamp = v;
	endfunction

	logic [3:0] pin_s;
	logic rx_s;
	logic cts_s;
	logic tick;
	hspb_cfg_type cfg_reg;
	logic [DIV_W-1:0] div_reg;
	logic [BRK_W-1:0] brk_reg;
	logic [NIRQ-1:0] istat_reg;
	logic [NIRQ-1:0] imask_reg;
	logic [NIRQ-1:0] ev;
	logic bypass_reg;
	logic wr_reg;
	logic rd_reg;
	logic [7:0] addr_reg;
	logic accept;
	logic wr_now;
	logic rd_pop;
	logic [7:0] rx_data_reg;
	logic rx_valid_reg;
	logic [7:0] rx_sh_reg;
	logic [2:0] rx_cnt_reg;
	logic [2:0] rx_bit_reg;
	hspb_rx_type rx_st_reg;
	logic [7:0] tx_hold_reg;
	logic tx_pend_reg;
	logic [7:0] tx_sh_reg;
	logic [2:0] tx_cnt_reg;
	logic [2:0] tx_bit_reg;
	logic tx_line_reg;
	hspb_tx_type tx_st_reg;
	logic [MSC_W-1:0] ms_cnt_reg;
	logic [BRK_W-1:0] low_ms_reg;
	logic brk_done_reg;
	logic [BRK_W-1:0] brk_lim;
	hspb_stat_type stat;
	logic port_on;
	logic [31:0] rd_next;

	hspb_sync #(.W(4), .INIT(4'hd)) u_sync (
		.CLK(CLK),
		.RESETN(RESETN),
		.D({GP_I[3], GP_I[1], CTS_N, RXD}),
		.Q(pin_s)
	);
	assign rx_s = pin_s[0];
	assign cts_s = pin_s[1];

	// own port stops serving once bypass is in effect
	assign port_on = !bypass_reg;

	hspb_baud u_baud (
		.CLK(CLK),
		.RESETN(RESETN),
		.DIV(div_reg),
		.RUN(port_on),
		.TICK(tick)
	);

	// bus slave: writes finish in one cycle, reads insert one wait state
	assign accept = HSEL && HTRANS[1] && HREADY && (HSIZE == HSIZE_WORD);
	assign wr_now = wr_reg;
	assign HREADYOUT = !rd_reg;
	assign HRESP = 1'b0;

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			addr_reg <= '0;
		end
		else
		begin
			wr_reg <= accept && HWRITE;
			rd_reg <= accept && !HWRITE;
			if (accept)
				addr_reg <= {HADDR[7:2], 2'b00};
		end
	end

	assign stat = '{bypass: bypass_reg, cts_n: cts_s, tx_pend: tx_pend_reg,
		tx_busy: (tx_st_reg != TX_IDLE), rx_valid: rx_valid_reg};

	always_comb
	begin
		rd_next = '0;
		if (addr_reg == OFS_CTRL)
			rd_next = 32'(cfg_reg);
		else if (addr_reg == OFS_BAUD)
			rd_next = 32'(div_reg);
		else if (addr_reg == OFS_BRK)
			rd_next = 32'(brk_reg);
		else if (addr_reg == OFS_RXD)
			rd_next = 32'(rx_data_reg);
		else if (addr_reg == OFS_STAT)
			rd_next = 32'(stat);
		else if (addr_reg == OFS_ISTAT)
			rd_next = 32'(istat_reg);
		else if (addr_reg == OFS_IMASK)
			rd_next = 32'(imask_reg);
	end

	assign rd_pop = rd_reg && (addr_reg == OFS_RXD);

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			HRDATA <= '0;
		else if (rd_reg)
			HRDATA <= rd_next;
	end

	// configuration registers
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			cfg_reg <= CFG_RST;
			div_reg <= BAUD_DIV_RST;
			brk_reg <= BRK_RST;
			imask_reg <= '0;
		end
		else if (wr_now)
		begin
			if (addr_reg == OFS_CTRL)
				cfg_reg <= HWDATA[CFG_W-1:0];
			else if (addr_reg == OFS_BAUD)
				div_reg <= HWDATA[DIV_W-1:0];
			else if (addr_reg == OFS_BRK)
				brk_reg <= HWDATA[BRK_W-1:0];
			else if (addr_reg == OFS_IMASK)
				imask_reg <= HWDATA[NIRQ-1:0];
		end
	end

	// bypass is sticky; there is no write that clears it
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			bypass_reg <= 1'b0;
		else if (wr_now && addr_reg == OFS_CMD && HWDATA == CMD_BYPASS)
			bypass_reg <= 1'b1;
	end

	// transmit holding word; a write while one is pending is dropped
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			tx_hold_reg <= '0;
			tx_pend_reg <= 1'b0;
		end
		else if (wr_now && addr_reg == OFS_TXD && !tx_pend_reg && port_on)
		begin
			tx_hold_reg <= HWDATA[7:0];
			tx_pend_reg <= 1'b1;
		end
		else if (tx_st_reg == TX_IDLE && tx_pend_reg && tick && !cfg_reg.send_break
			&& (!cfg_reg.flow_en || !cts_s))
			tx_pend_reg <= 1'b0;
	end

	// transmitter: each bit lasts OVS ticks
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			tx_st_reg <= TX_IDLE;
			tx_sh_reg <= '0;
			tx_cnt_reg <= '0;
			tx_bit_reg <= '0;
			tx_line_reg <= 1'b1;
		end
		else if (tick)
		begin
			tx_cnt_reg <= tx_cnt_reg + 3'd1;
			case (tx_st_reg)
				TX_IDLE:
				begin
					tx_cnt_reg <= '0;
					tx_line_reg <= !cfg_reg.send_break;
					if (tx_pend_reg && !cfg_reg.send_break && (!cfg_reg.flow_en || !cts_s))
					begin
						tx_sh_reg <= tx_hold_reg;
						tx_line_reg <= 1'b0;
						tx_st_reg <= TX_START;
					end
				end
				TX_START:
					if (tx_cnt_reg == OVS_LAST)
					begin
						tx_line_reg <= tx_sh_reg[0];
						tx_bit_reg <= '0;
						tx_st_reg <= TX_DATA;
					end
				TX_DATA:
					if (tx_cnt_reg == OVS_LAST)
					begin
						tx_bit_reg <= tx_bit_reg + 3'd1;
						tx_line_reg <= tx_sh_reg[tx_bit_reg + 3'd1];
						if (tx_bit_reg == 3'd7)
						begin
							tx_line_reg <= (cfg_reg.parity == PAR_NONE) ? 1'b1
								: par_bit(tx_sh_reg, cfg_reg.parity);
							tx_st_reg <= (cfg_reg.parity == PAR_NONE) ? TX_STOP1 : TX_PAR;
						end
					end
				TX_PAR:
					if (tx_cnt_reg == OVS_LAST)
					begin
						tx_line_reg <= 1'b1;
						tx_st_reg <= TX_STOP1;
					end
				TX_STOP1:
					if (tx_cnt_reg == OVS_LAST)
						tx_st_reg <= cfg_reg.stop2 ? TX_STOP2 : TX_IDLE;
				TX_STOP2:
					if (tx_cnt_reg == OVS_LAST)
						tx_st_reg <= TX_IDLE;
				default:
					tx_st_reg <= TX_IDLE;
			endcase
		end
	end

	// receiver: start bit checked at mid bit, then one sample per bit
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rx_st_reg <= RX_IDLE;
			rx_sh_reg <= '0;
			rx_cnt_reg <= '0;
			rx_bit_reg <= '0;
		end
		else if (tick)
		begin
			rx_cnt_reg <= rx_cnt_reg + 3'd1;
			case (rx_st_reg)
				RX_IDLE:
				begin
					rx_cnt_reg <= '0;
					if (!rx_s)
						rx_st_reg <= RX_START;
				end
				RX_START:
					if (rx_cnt_reg == OVS_HALF)
					begin
						rx_cnt_reg <= '0;
						rx_bit_reg <= '0;
						rx_st_reg <= rx_s ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (rx_cnt_reg == OVS_LAST)
					begin
						rx_sh_reg <= {rx_s, rx_sh_reg[7:1]};
						rx_bit_reg <= rx_bit_reg + 3'd1;
						if (rx_bit_reg == 3'd7)
							rx_st_reg <= (cfg_reg.parity == PAR_NONE) ? RX_STOP : RX_PAR;
					end
				RX_PAR:
					if (rx_cnt_reg == OVS_LAST)
						rx_st_reg <= RX_STOP;
				RX_STOP:
					if (rx_cnt_reg == OVS_LAST)
						rx_st_reg <= RX_IDLE;
				default:
					rx_st_reg <= RX_IDLE;
			endcase
		end
	end

	// one-word receive buffer; a new character overwrites and flags overrun
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rx_data_reg <= '0;
			rx_valid_reg <= 1'b0;
		end
		else if (tick && rx_st_reg == RX_STOP && rx_cnt_reg == OVS_LAST)
		begin
			rx_data_reg <= rx_sh_reg;
			rx_valid_reg <= 1'b1;
		end
		else if (rd_pop)
			rx_valid_reg <= 1'b0;
	end

	// break detector counts whole milliseconds of continuous low
	assign brk_lim = brk_clamp(brk_reg);
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ms_cnt_reg <= '0;
			low_ms_reg <= '0;
			brk_done_reg <= 1'b0;
			RESET_REQ <= 1'b0;
		end
		else
		begin
			RESET_REQ <= 1'b0;
			if (rx_s || !port_on)
			begin
				ms_cnt_reg <= '0;
				low_ms_reg <= '0;
				brk_done_reg <= 1'b0;
			end
			else if (ms_cnt_reg == MS_LAST)
			begin
				ms_cnt_reg <= '0;
				if (low_ms_reg != BRK_MAX)
					low_ms_reg <= low_ms_reg + 18'h0_0001;
				// zero timeout disables reset, and a held low fires only once
				if (brk_lim != '0 && low_ms_reg >= brk_lim && !brk_done_reg)
				begin
					RESET_REQ <= 1'b1;
					brk_done_reg <= 1'b1;
				end
			end
			else
				ms_cnt_reg <= ms_cnt_reg + MSC_W'(1);
		end
	end

	// sticky events, write one to clear; a same-cycle event wins
	always_comb
	begin
		ev = '0;
		ev[IRQ_RXDONE] = tick && rx_st_reg == RX_STOP && rx_cnt_reg == OVS_LAST;
		ev[IRQ_TXDONE] = tick && tx_cnt_reg == OVS_LAST && ((tx_st_reg == TX_STOP1
			&& !cfg_reg.stop2) || tx_st_reg == TX_STOP2);
		ev[IRQ_PARERR] = tick && rx_st_reg == RX_PAR && rx_cnt_reg == OVS_LAST
			&& rx_s != par_bit(rx_sh_reg, cfg_reg.parity);
		ev[IRQ_FRMERR] = ev[IRQ_RXDONE] && !rx_s;
		ev[IRQ_OVERRUN] = ev[IRQ_RXDONE] && rx_valid_reg && !rd_pop;
		ev[IRQ_BREAK] = RESET_REQ;
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			istat_reg <= '0;
		else if (wr_now && addr_reg == OFS_ISTAT)
			istat_reg <= (istat_reg & ~HWDATA[NIRQ-1:0]) | ev;
		else
			istat_reg <= istat_reg | ev;
	end

	assign IRQ = |(istat_reg & imask_reg);

	// pin drivers: all enables low under reset, own port or bypass routing after
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			TXD_O <= 1'b1;
			TXD_OE <= 1'b0;
			RTS_N_O <= 1'b1;
			RTS_N_OE <= 1'b0;
			GP_O <= '0;
			GP_OE <= '0;
			DEEP_SLEEP <= 1'b0;
		end
		else
		begin
			TXD_OE <= 1'b1;
			RTS_N_OE <= 1'b1;
			DEEP_SLEEP <= bypass_reg;
			if (bypass_reg)
			begin
				TXD_O <= pin_s[2];
				RTS_N_O <= pin_s[3];
				GP_O <= {1'b0, cts_s, 1'b0, rx_s};
				GP_OE <= GP_OE_BYP;
			end
			else
			begin
				TXD_O <= tx_line_reg;
				RTS_N_O <= cfg_reg.flow_en && rx_valid_reg;
				GP_O <= '0;
				GP_OE <= '0;
			end
		end
	end
endmodule
`default_nettype wire

// file: dv/hspb_uart_port_assertions.sv
// pin and bus checks for the serial host port
`default_nettype none
module hspb_uart_port_assertions
	import hspb_pkg::*;
#(
	parameter int MS_CYCLES = hspb_pkg::MS_CYCLES
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic HREADY,
	input wire logic HREADYOUT,
	input wire logic RXD,
	input wire logic TXD_O,
	input wire logic TXD_OE,
	input wire logic RTS_N_OE,
	input wire logic [3:0] GP_I,
	input wire logic [3:0] GP_O,
	input wire logic [3:0] GP_OE,
	input wire logic DEEP_SLEEP,
	input wire logic RESET_REQ
);
	timeunit 1ns;
	timeprecision 100ps;
	// at least the shortest timeout of low (1000 ms) must pass before a reset request may appear
	localparam int MIN_LOW = 1000 * MS_CYCLES;
	logic take;
	bit seen_rst;
	int unsigned low_cnt;
	assign take = HSEL && HTRANS[1] && HREADY && HSIZE == HSIZE_WORD;
	always_ff @(posedge CLK)
		seen_rst <= !RESETN;
	always_ff @(posedge CLK or negedge RESETN)
		if (!RESETN)
			low_cnt <= 0;
		else
			low_cnt <= RXD ? 0 : low_cnt + 1;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	a_float_rst: assert property (disable iff (1'b0)
		!RESETN && seen_rst |-> !TXD_OE && !RTS_N_OE && GP_OE == 4'h0)
		else $error("serial pins driven during reset");
	a_own_port: assert property ($rose(RESETN) |=>
		TXD_OE && RTS_N_OE && !DEEP_SLEEP && GP_OE == 4'h0)
		else $error("own port not connected after reset");
	a_bypass_pins: assert property (DEEP_SLEEP |-> GP_OE == 4'h5)
		else $error("bypass pin enables wrong");
	a_bypass_route: assert property (DEEP_SLEEP && $past(DEEP_SLEEP, 4) |->
		GP_O[0] == $past(RXD, 3) && TXD_O == $past(GP_I[1], 3))
		else $error("bypass routing wrong");
	a_sleep_holds: assert property (DEEP_SLEEP |=> DEEP_SLEEP [*8])
		else $error("deep sleep left without reset");
	a_sleep_quiet: assert property (DEEP_SLEEP |-> !RESET_REQ)
		else $error("break reset while asleep");
	a_reset_pulse: assert property (RESET_REQ |-> !RXD && $past(!RXD) ##1 !RESET_REQ)
		else $error("reset request not a pulse on a low line");
	a_break_low: assert property (RESET_REQ |-> low_cnt >= MIN_LOW)
		else $error("reset request before the shortest timeout");
	a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
		else $error("write stalled");
endmodule
`default_nettype wire

// file: dv/hspb_host_model.sv
// behavioural host: sends frames on the receive pin, decodes the transmit pin
`default_nettype none
module hspb_host_model #(
	parameter int BIT = 347
) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got;
	int got_cnt;
	initial
	begin
		rxd = 1'b1;
		got = 8'h00;
		got_cnt = 0;
	end
	task automatic set_rxd(input logic v);
		@(posedge clk);
		rxd <= v;
	endtask
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			set_rxd(f[i]);
			repeat (BIT - 1) @(posedge clk);
		end
	endtask
	// mid-bit sampling tolerates the divisor's fractional jitter
	always
	begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge clk);
		if (txd === 1'b0)
		begin
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge clk);
				got[i] = txd;
			end
			repeat (BIT) @(posedge clk);
			got_cnt++;
		end
	end
endmodule
`default_nettype wire

// file: dv/hspb_uart_port_tb_top.sv
// self-checking bench for the serial host port with bypass
`default_nettype none
module hspb_uart_port_tb_top;
	import hspb_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic wr;
		logic [7:0] ofs;
		logic [31:0] wd;
		logic [31:0] exp;
	} hspb_row_type;
	`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
		$display("mismatch %s expected %h seen %h", n, e, g); end end
	localparam hspb_row_type ROWS [10] = '{
		'{1'b0, OFS_BAUD, 32'h0000_0000, 32'h0000_01d8},
		'{1'b0, OFS_BRK, 32'h0000_0000, 32'h0000_0000},
		'{1'b0, OFS_CTRL, 32'h0000_0000, 32'h0000_0000},
		'{1'b0, OFS_STAT, 32'h0000_0000, 32'h0000_0000},
		'{1'b1, OFS_CTRL, 32'h0000_0006, 32'h0000_0006},
		'{1'b1, OFS_BAUD, 32'h0000_0027, 32'h0000_0027},
		'{1'b1, OFS_BAUD, 32'h0000_01d8, 32'h0000_01d8},
		'{1'b1, OFS_IMASK, 32'h0000_003f, 32'h0000_003f},
		'{1'b1, 8'h40, 32'hffff_ffff, 32'h0000_0000},
		'{1'b1, OFS_CTRL, 32'h0000_0008, 32'h0000_0008}
	};
	logic clk, resetn, hsel, hwrite, hreadyout, hresp, rxd, txd_o, txd_oe, cts_n;
	logic rts_n_o, rts_n_oe, deep_sleep, reset_req, irq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [3:0] gp_i, gp_o, gp_oe;
	wire logic txd_line;
	int num_errors, cmp_count, n;
	// weak pull-up keeps the floating transmit pin idle
	assign txd_line = txd_oe ? txd_o : 1'b1;
	hspb_uart_port #(.MS_CYCLES(40)) dut_u (.CLK(clk), .RESETN(resetn), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
		.RXD(rxd), .TXD_O(txd_o), .TXD_OE(txd_oe), .CTS_N(cts_n), .RTS_N_O(rts_n_o),
		.RTS_N_OE(rts_n_oe), .GP_I(gp_i), .GP_O(gp_o), .GP_OE(gp_oe),
		.DEEP_SLEEP(deep_sleep), .RESET_REQ(reset_req), .IRQ(irq));
	hspb_host_model #(.BIT(347)) host_u (.clk(clk), .txd(txd_line), .rxd(rxd));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wait_rdy();
		logic r;
		do
		begin
			@(negedge clk);
			r = hreadyout;
			d = hrdata;
			@(posedge clk);
		end
		while (r !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
		@(posedge clk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, ofs};
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		@(negedge clk);
	endtask
	initial
	begin
		#2_000_000;
		num_errors++;
		complete_run();
	end
	initial
	begin
		resetn = 1'b0;
		hsel = 1'b1;
		htrans = 2'h0;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0000_0000;
		cts_n = 1'b0;
		gp_i = 4'h0;
		repeat (2) @(negedge clk);
		`CHK("TXD_OE", 1'b0, txd_oe)
		`CHK("RTS_N_OE", 1'b0, rts_n_oe)
		@(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(negedge clk);
		`CHK("TXD_OE", 1'b1, txd_oe)
		foreach (ROWS[i])
		begin
			if (ROWS[i].wr)
				bus(1'b1, ROWS[i].ofs, ROWS[i].wd);
			bus(1'b0, ROWS[i].ofs, 32'h0000_0000);
			`CHK("register", ROWS[i].exp, d)
			`CHK("HRESP", 1'b0, hresp)
		end
		host_u.send_byte(8'ha5);
		@(negedge clk);
		`CHK("IRQ", 1'b1, irq)
		`CHK("RTS_N_O", 1'b1, rts_n_o)
		bus(1'b0, OFS_RXD, 32'h0000_0000);
		`CHK("RXDATA", 32'h0000_00a5, d)
		`CHK("RTS_N_O", 1'b0, rts_n_o)
		bus(1'b1, OFS_IMASK, 32'h0000_0000);
		`CHK("IRQ", 1'b0, irq)
		bus(1'b1, OFS_IMASK, 32'h0000_0001);
		`CHK("IRQ", 1'b1, irq)
		@(posedge clk);
		hsize <= 3'h0;
		bus(1'b1, OFS_IMASK, 32'h0000_0000);
		@(posedge clk);
		hsize <= HSIZE_WORD;
		hsel <= 1'b0;
		bus(1'b1, OFS_IMASK, 32'h0000_0000);
		@(posedge clk);
		hsel <= 1'b1;
		bus(1'b0, OFS_IMASK, 32'h0000_0000);
		`CHK("IMASK", 32'h0000_0001, d)
		bus(1'b1, OFS_ISTAT, 32'h0000_0001);
		`CHK("IRQ", 1'b0, irq)
		@(posedge clk);
		cts_n <= 1'b1;
		bus(1'b1, OFS_TXD, 32'h0000_003c);
		repeat (700) @(negedge clk);
		`CHK("TXD_O", 1'b1, txd_o)
		n = host_u.got_cnt;
		@(posedge clk);
		cts_n <= 1'b0;
		repeat (5000) @(negedge clk);
		`CHK("tx byte", 8'h3c, host_u.got)
		`CHK("tx count", n + 1, host_u.got_cnt)
		bus(1'b1, OFS_CTRL, 32'h0000_0018);
		repeat (100) @(negedge clk);
		`CHK("TXD_O", 1'b0, txd_o)
		bus(1'b1, OFS_CTRL, 32'h0000_0008);
		bus(1'b1, OFS_BRK, 32'h0000_03e8);
		host_u.set_rxd(1'b0);
		n = 0;
		while (reset_req !== 1'b1 && n < 41000)
		begin
			@(negedge clk);
			n++;
		end
		`CHK("break span", 1'b1, n >= 39900 && n <= 40100)
		host_u.set_rxd(1'b1);
		bus(1'b0, OFS_ISTAT, 32'h0000_0000);
		`CHK("break flag", 1'b1, d[5])
		bus(1'b1, OFS_CMD, CMD_BYPASS);
		repeat (6) @(negedge clk);
		`CHK("DEEP_SLEEP", 1'b1, deep_sleep)
		`CHK("GP_OE", 4'h5, gp_oe)
		@(posedge clk);
		gp_i <= 4'ha;
		cts_n <= 1'b1;
		repeat (5) @(negedge clk);
		`CHK("TXD_O", 1'b1, txd_o)
		`CHK("RTS_N_O", 1'b1, rts_n_o)
		host_u.set_rxd(1'b0);
		repeat (5) @(negedge clk);
		`CHK("GP_O", 4'h4, gp_o)
		host_u.set_rxd(1'b1);
		bus(1'b1, OFS_CMD, 32'h0000_0000);
		`CHK("DEEP_SLEEP", 1'b1, deep_sleep)
		@(posedge clk);
		resetn <= 1'b0;
		@(negedge clk);
		`CHK("TXD_OE", 1'b0, txd_oe)
		`CHK("GP_OE", 4'h0, gp_oe)
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(negedge clk);
		`CHK("DEEP_SLEEP", 1'b0, deep_sleep)
		`CHK("GP_OE", 4'h0, gp_oe)
		`CHK("TXD_OE", 1'b1, txd_oe)
		complete_run();
	end
endmodule
bind hspb_uart_port hspb_uart_port_assertions #(.MS_CYCLES(MS_CYCLES)) chk_u (.CLK(CLK),
	.RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
	.HREADY(HREADY), .HREADYOUT(HREADYOUT), .RXD(RXD), .TXD_O(TXD_O), .TXD_OE(TXD_OE),
	.RTS_N_OE(RTS_N_OE), .GP_I(GP_I), .GP_O(GP_O), .GP_OE(GP_OE),
	.DEEP_SLEEP(DEEP_SLEEP), .RESET_REQ(RESET_REQ));
`default_nettype wire
